// ### ssw_params.svh
/*
 * Constants for the standby, wake-up and warm-up controller: register
 * offsets, field positions, reset values and timing figures.
 * Assumes inclusion by bare name from the warm-up and controller design files.
 */
`ifndef SSW_PARAMS_SVH
`define SSW_PARAMS_SVH

`define SSW_OFS_STANDBY 8'h00
`define SSW_OFS_OSC 8'h04
`define SSW_OFS_WAKE 8'h08
`define SSW_OFS_STATUS 8'h0C

`define SSW_STBY_STOP 3'h1
`define SSW_STBY_SLEEP 3'h2
`define SSW_STBY_IDLE 3'h3
`define SSW_STBY_RST 3'h0

`define SSW_OSC_SEL_BIT 0
`define SSW_OSC_WARMUP_TIME_LSB 4
`define SSW_OSC_HS_BIT 8
`define SSW_OSC_LS_BIT 9
`define SSW_OSC_PLL_BIT 10
`define SSW_OSC_SLOW_BIT 12
`define SSW_OSC_SWWU_BIT 16
`define SSW_WARMUP_TIME_RST 3'h7
`define SSW_WAKE_RTC_BIT 8
`define SSW_WAKE_RST 9'h000

`define SSW_ST_BUSY_BIT 3
`define SSW_ST_PRIOR_BIT 4
`define SSW_ST_SLOW_BIT 5
`define SSW_ST_NMI_BIT 6

`define SSW_WU_BASE_LOG2 8
`define SSW_WU_STEP_LOG2 2
`define SSW_CLK_PERIOD_NS 100
`define SSW_PLL_LOCK_NS 200000
`define SSW_PLL_LOCK_CYC \
    ((`SSW_PLL_LOCK_NS + `SSW_CLK_PERIOD_NS - 1) / `SSW_CLK_PERIOD_NS)

`endif

// ### ssw_pkg.sv
/*
 * Types shared by the standby controller modules.
 * Assumes nothing of its surroundings.
 */
package ssw_pkg;
    typedef enum logic [2:0] {
        SSW_NORMAL,
        SSW_SLOW,
        SSW_IDLE,
        SSW_SLEEP,
        SSW_STOP,
        SSW_WARMUP
    } ssw_mode_type;
endpackage : ssw_pkg

// ### ssw_sync.sv
/*
 * Two-stage synchroniser bank for pin inputs.
 * Assumes inputs asynchronous to sys_clk; ce freezes both stages.
 */
`timescale 1ns/100ps
`default_nettype none
module ssw_sync #(
    parameter int WIDTH = 9
) (
    input wire logic sys_clk,            // system clock
    input wire logic rstn,               // sync reset, active low
    input wire logic ce,                 // clock enable
    input wire logic [WIDTH-1:0] d,      // asynchronous pins
    output logic [WIDTH-1:0] q           // synchronised levels
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] next_meta;
    logic [WIDTH-1:0] next_q;

    initial begin
        if (WIDTH < 1) begin
            $error("ssw_sync width must be at least one");
        end
    end

    always_comb begin
        next_meta = ce ? d : meta;
        next_q = ce ? meta : q;
        if (!rstn) begin
            next_meta = '0;
            next_q = '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        meta <= next_meta;
        q <= next_q;
    end
endmodule : ssw_sync
`default_nettype wire

// ### ssw_warmup.sv
/*
 * Warm-up counter: counts ticks of the oscillator chosen for warm-up
 * up to 2^(base + step*time) and, when asked, a PLL lock floor too.
 * Assumes tick inputs are one-cycle enables on sys_clk.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ssw_params.svh"
module ssw_warmup #(
    parameter int CW = 23,
    parameter int PLL_CYC = `SSW_PLL_LOCK_CYC
) (
    input wire logic sys_clk,            // system clock
    input wire logic rstn,               // sync reset, active low
    input wire logic ce,                 // clock enable
    input wire logic start,              // restart count from zero
    input wire logic source_sel,         // 0 high-speed, 1 low-speed
    input wire logic [2:0] warmup_time,  // programmed time code
    input wire logic need_pll,           // also wait for pll lock
    input wire logic hs_tick,            // high-speed oscillator tick
    input wire logic ls_tick,            // low-speed oscillator tick
    output logic busy,                   // counting
    output logic done                    // one-cycle end pulse
);
    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic [15:0] pll_cnt;
    logic [15:0] next_pll_cnt;
    logic next_busy;
    logic next_done;
    logic [CW-1:0] target;
    logic tick;

    initial begin
        if (CW < `SSW_WU_BASE_LOG2 + 7 * `SSW_WU_STEP_LOG2 + 1 ||
            PLL_CYC < 1 || PLL_CYC > 65535) begin
            $error("ssw_warmup parameters out of range");
        end
    end

    // the counter runs on the oscillator being warmed, not on sys_clk
    assign tick = source_sel ? ls_tick : hs_tick;
    assign target = CW'(1) << (`SSW_WU_BASE_LOG2 +
                    `SSW_WU_STEP_LOG2 * int'(warmup_time));

    always_comb begin
        next_cnt = cnt;
        next_pll_cnt = pll_cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (start) begin
            next_cnt = '0;
            next_pll_cnt = need_pll ? 16'(PLL_CYC) : 16'h0000;
            next_busy = 1'b1;
        end else if (busy) begin
            if (tick && cnt != target) begin
                next_cnt = cnt + CW'(1);
            end
            if (pll_cnt != 16'h0000) begin
                next_pll_cnt = pll_cnt - 16'h0001;
            end
            if (cnt == target && pll_cnt == 16'h0000) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
        if (!ce) begin
            next_cnt = cnt;
            next_pll_cnt = pll_cnt;
            next_busy = busy;
            next_done = done;
        end
        if (!rstn) begin
            next_cnt = '0;
            next_pll_cnt = 16'h0000;
            next_busy = 1'b0;
            next_done = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        cnt <= next_cnt;
        pll_cnt <= next_pll_cnt;
        busy <= next_busy;
        done <= next_done;
    end

    a_done_at_target: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && done |-> $past(cnt) == $past(target))
        else $error("warm-up ended before target count");
endmodule : ssw_warmup
`default_nettype wire

// ### ssw_ctrl.sv
/*
 * Standby controller: mode state machine for normal, slow, idle, sleep
 * and stop, per-mode wake source qualification, automatic and software
 * warm-up, oscillator and clock gating, AHB-Lite register slave.
 * Assumes peripheral interrupts are sys_clk levels and that the cpu
 * raises sleep_req when it executes its wait-for-interrupt instruction.
 */
`timescale 1ns/100ps
`default_nettype none
`include "ssw_params.svh"
// Behaviour
// - wake only by interrupt, nmi, reset per mode
// - wake request handed to cpu after release
// - watchdog nmi wakes idle only
// - nmi pin wakes every low power mode
// - timer and capture interrupts wake idle only
// - serial, bus, converter interrupts wake idle only
// - sleep/stop wake needs cpu and detect enable
// - pin reset returns to normal, clears registers; osc resets to 0x770 instead
// - reset exit from stop has no warm-up
// - stop or sleep-to-normal exit auto warms up
// - pll off in sleep/stop, lock time covered
// - listed transitions need no warm-up
// - sleep to slow proceeds without warm-up
// - wake returns to mode held before entry
// - standby field 001 stop, 010 sleep, 011 idle
module ssw_ctrl
    import ssw_pkg::*;
#(
    parameter int N_TIMER = 10,
    parameter int N_CAPTURE = 14,
    parameter int N_SERIAL = 3,
    parameter int N_CONV = 3
) (
    input wire logic sys_clk,                        // system clock
    input wire logic rstn,                           // sync reset, low
    input wire logic ce,                             // clock enable
    input wire logic hsel,                           // ahb select
    input wire logic [7:0] haddr,                    // ahb address
    input wire logic [1:0] htrans,                   // ahb transfer type
    input wire logic hwrite,                         // ahb write
    input wire logic [2:0] hsize,                    // ahb size
    input wire logic [31:0] hwdata,                  // ahb write data
    input wire logic hready,                         // ahb bus ready
    output logic hreadyout,                          // ahb slave ready
    output logic hresp,                              // ahb response
    output logic [31:0] hrdata,                      // ahb read data
    input wire logic sleep_req,                      // cpu wait pulse
    input wire logic cpu_irq_enabled,                // cpu takes irqs
    input wire logic [7:0] external_pin_interrupts,  // irq pins, async
    input wire logic nmi_pin,                        // nmi pin, async
    input wire logic watchdog_nmi_request,           // watchdog nmi
    input wire logic rtc_interrupt,                  // rtc irq
    input wire logic [N_TIMER-1:0] timer_interrupt,  // timer irqs
    input wire logic [N_CAPTURE-1:0] capture_interrupt, // capture irqs
    input wire logic [N_SERIAL-1:0] serial_receive_interrupt, // rx
    input wire logic [N_SERIAL-1:0] serial_transmit_interrupt, // tx
    input wire logic [N_SERIAL-1:0] serial_bus_interrupt, // bus irqs
    input wire logic [N_CONV-1:0] converter_interrupt, // converter
    input wire logic hs_tick,                        // fast osc tick
    input wire logic ls_tick,                        // slow osc tick
    output ssw_pkg::ssw_mode_type mode,              // current mode
    output logic cpu_clk_en,                         // cpu clock gate
    output logic sys_clk_en,                         // system clock gate
    output logic pll_en,                             // pll enable
    output logic hs_osc_en,                          // fast osc enable
    output logic ls_osc_en,                          // slow osc enable
    output logic wake_release,                       // release pulse
    output logic wake_by_nmi                         // release was nmi
);
    import ssw_pkg::*;

    ssw_mode_type next_mode;
    logic prior_slow, next_prior_slow;
    logic next_wake_release, next_wake_by_nmi;
    logic [2:0] standby, next_standby;
    logic [31:0] osc, next_osc;
    logic [8:0] wake_en, next_wake_en;
    logic ph_valid, next_ph_valid;
    logic ph_write, next_ph_write;
    logic [7:0] ph_addr, next_ph_addr;
    logic [31:0] next_hrdata;
    logic [8:0] pins_sync;
    logic [7:0] ext_sync;
    logic nmi_sync;
    logic wu_start, wu_busy, wu_done, wu_need_pll, sw_wu;
    logic periph_irq, idle_wake, sleep_wake, stop_wake, nmi_wake;
    logic addr_phase, wr_osc;

    initial begin
        if (N_TIMER < 1 || N_CAPTURE < 1 || N_SERIAL < 1 || N_CONV < 1) begin
            $error("ssw_ctrl source counts must be at least one");
        end
    end

    ssw_sync #(.WIDTH(9)) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .d({nmi_pin, external_pin_interrupts}),
        .q(pins_sync)
    );
    assign ext_sync = pins_sync[7:0];
    assign nmi_sync = pins_sync[8];

    // wake qualification per mode
    assign periph_irq = rtc_interrupt | (|timer_interrupt) |
        (|capture_interrupt) | (|serial_receive_interrupt) |
        (|serial_transmit_interrupt) | (|serial_bus_interrupt) |
        (|converter_interrupt);
    assign idle_wake = (cpu_irq_enabled & ((|ext_sync) | periph_irq)) |
        watchdog_nmi_request | nmi_sync;
    assign sleep_wake = (cpu_irq_enabled & ((|(ext_sync & wake_en[7:0])) |
        (rtc_interrupt & wake_en[`SSW_WAKE_RTC_BIT]))) | nmi_sync;
    assign stop_wake = (cpu_irq_enabled & (|(ext_sync & wake_en[7:0]))) |
        nmi_sync;
    assign nmi_wake = nmi_sync | (mode == SSW_IDLE && watchdog_nmi_request);

    // software warm-up: a write of the start bit while running
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_osc = ce && ph_valid && ph_write && ph_addr == `SSW_OFS_OSC;
    assign sw_wu = wr_osc && hwdata[`SSW_OSC_SWWU_BIT] && !wu_busy &&
        (mode == SSW_NORMAL || mode == SSW_SLOW);

    // mode state machine
    always_comb begin
        next_mode = mode;
        next_prior_slow = prior_slow;
        next_wake_release = 1'b0;
        next_wake_by_nmi = wake_by_nmi;
        wu_start = sw_wu;
        wu_need_pll = 1'b0;
        case (mode)
            SSW_NORMAL, SSW_SLOW: begin
                if (sleep_req) begin
                    next_prior_slow = (mode == SSW_SLOW);
                    case (standby)
                        `SSW_STBY_IDLE: next_mode = SSW_IDLE;
                        `SSW_STBY_SLEEP: next_mode = SSW_SLEEP;
                        `SSW_STBY_STOP: next_mode = SSW_STOP;
                        default: next_mode = mode;
                    endcase
                end else if (!osc[`SSW_OSC_SLOW_BIT]) begin
                    next_mode = SSW_NORMAL;
                end else begin
                    next_mode = SSW_SLOW;
                end
            end
            SSW_IDLE: begin
                if (idle_wake) begin
                    next_mode = prior_slow ? SSW_SLOW : SSW_NORMAL;
                    next_wake_release = 1'b1;
                    next_wake_by_nmi = nmi_wake;
                end
            end
            SSW_SLEEP: begin
                if (sleep_wake) begin
                    next_wake_by_nmi = nmi_sync;
                    if (prior_slow) begin
                        next_mode = SSW_SLOW;
                        next_wake_release = 1'b1;
                    end else begin
                        next_mode = SSW_WARMUP;
                        wu_start = 1'b1;
                        wu_need_pll = 1'b1;
                    end
                end
            end
            SSW_STOP: begin
                if (stop_wake) begin
                    next_mode = SSW_WARMUP;
                    next_wake_by_nmi = nmi_sync;
                    wu_start = 1'b1;
                    wu_need_pll = !prior_slow;
                end
            end
            SSW_WARMUP: begin
                if (wu_done) begin
                    next_mode = prior_slow ? SSW_SLOW : SSW_NORMAL;
                    next_wake_release = 1'b1;
                end
            end
            default: next_mode = SSW_NORMAL;
        endcase
        if (!ce) begin
            next_mode = mode;
            next_prior_slow = prior_slow;
            next_wake_release = wake_release;
            next_wake_by_nmi = wake_by_nmi;
            wu_start = 1'b0;
        end
        if (!rstn) begin
            next_mode = SSW_NORMAL;
            next_prior_slow = 1'b0;
            next_wake_release = 1'b0;
            next_wake_by_nmi = 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        mode <= next_mode;
        prior_slow <= next_prior_slow;
        wake_release <= next_wake_release;
        wake_by_nmi <= next_wake_by_nmi;
    end

    ssw_warmup u_warmup (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ce(ce),
        .start(wu_start),
        .source_sel(osc[`SSW_OSC_SEL_BIT]),
        .warmup_time(osc[`SSW_OSC_WARMUP_TIME_LSB +: 3]),
        .need_pll(wu_need_pll),
        .hs_tick(hs_tick),
        .ls_tick(ls_tick),
        .busy(wu_busy),
        .done(wu_done)
    );

    // clock gating: the system clock waits for the warm-up
    assign cpu_clk_en = (mode == SSW_NORMAL || mode == SSW_SLOW);
    assign sys_clk_en = cpu_clk_en || mode == SSW_IDLE;
    assign pll_en = osc[`SSW_OSC_PLL_BIT] && (mode == SSW_NORMAL ||
        mode == SSW_IDLE || (mode == SSW_WARMUP && !prior_slow));
    assign hs_osc_en = osc[`SSW_OSC_HS_BIT] && mode != SSW_SLEEP &&
        mode != SSW_STOP && !(mode == SSW_WARMUP && prior_slow);
    assign ls_osc_en = osc[`SSW_OSC_LS_BIT] && mode != SSW_STOP;

    // ahb-lite slave, zero wait states, every access answered okay
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_comb begin
        next_ph_valid = ce ? addr_phase : ph_valid;
        next_ph_write = (ce && addr_phase) ? hwrite : ph_write;
        next_ph_addr = (ce && addr_phase) ? haddr : ph_addr;
        next_standby = standby;
        next_osc = osc;
        next_wake_en = wake_en;
        next_hrdata = hrdata;
        if (ce && ph_valid && ph_write) begin
            case (ph_addr)
                `SSW_OFS_STANDBY: next_standby = hwdata[2:0];
                `SSW_OFS_OSC: next_osc = {16'h0000, hwdata[15:0]};
                `SSW_OFS_WAKE: next_wake_en = hwdata[8:0];
                default: next_standby = standby;
            endcase
        end
        // read data is fetched in the address phase so it leaves a flop
        if (ce && addr_phase && !hwrite) begin
            case (haddr)
                `SSW_OFS_STANDBY: next_hrdata = {29'h0, standby};
                `SSW_OFS_OSC: next_hrdata = osc;
                `SSW_OFS_WAKE: next_hrdata = {23'h0, wake_en};
                `SSW_OFS_STATUS: begin
                    next_hrdata = {29'h0, mode};
                    next_hrdata[`SSW_ST_BUSY_BIT] = wu_busy;
                    next_hrdata[`SSW_ST_PRIOR_BIT] = prior_slow;
                    next_hrdata[`SSW_ST_SLOW_BIT] = osc[`SSW_OSC_SLOW_BIT];
                    next_hrdata[`SSW_ST_NMI_BIT] = wake_by_nmi;
                end
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
        if (!rstn) begin
            next_ph_valid = 1'b0;
            next_ph_write = 1'b0;
            next_ph_addr = 8'h00;
            next_standby = `SSW_STBY_RST;
            next_osc = 32'h0000_0000;
            next_osc[`SSW_OSC_WARMUP_TIME_LSB +: 3] = `SSW_WARMUP_TIME_RST;
            next_osc[`SSW_OSC_HS_BIT] = 1'b1;
            next_osc[`SSW_OSC_LS_BIT] = 1'b1;
            next_osc[`SSW_OSC_PLL_BIT] = 1'b1;
            next_wake_en = `SSW_WAKE_RST;
            next_hrdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge sys_clk) begin
        ph_valid <= next_ph_valid;
        ph_write <= next_ph_write;
        ph_addr <= next_ph_addr;
        standby <= next_standby;
        osc <= next_osc;
        wake_en <= next_wake_en;
        hrdata <= next_hrdata;
    end

    // checks
    a_reset_normal: assert property (@(posedge sys_clk)
        !rstn |=> mode == SSW_NORMAL && !wu_busy)
        else $error("reset did not return to normal");
    // watchdog and timers may stand high here: only pins, rtc, nmi count
    a_wdt_not_sleep: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && mode == SSW_SLEEP && !nmi_sync && !rtc_interrupt &&
        !(|(ext_sync & wake_en[7:0])) |=> mode == SSW_SLEEP)
        else $error("sleep left without a permitted source");
    a_stop_periph: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && mode == SSW_STOP && !nmi_sync && !(|(ext_sync & wake_en[7:0]))
        |=> mode == SSW_STOP)
        else $error("stop left by a peripheral interrupt");
    a_nmi_all_modes: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && nmi_sync && (mode == SSW_IDLE || mode == SSW_SLEEP ||
        mode == SSW_STOP) |=> mode != $past(mode))
        else $error("nmi pin failed to release a low power mode");
    a_idle_periph: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && mode == SSW_IDLE && cpu_irq_enabled && |serial_bus_interrupt
        |=> cpu_clk_en ##0 wake_release)
        else $error("idle not released by serial bus interrupt");
    a_stop_warms: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && mode == SSW_STOP && stop_wake
        |=> mode == SSW_WARMUP && !sys_clk_en && wu_busy)
        else $error("stop exit skipped the warm-up");
    a_return_prior: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && mode == SSW_WARMUP && wu_done
        |=> mode == (prior_slow ? SSW_SLOW : SSW_NORMAL))
        else $error("wake did not return to the prior mode");
    a_sleep_slow: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && mode == SSW_SLEEP && prior_slow && sleep_wake
        |=> mode == SSW_SLOW && ls_osc_en == osc[`SSW_OSC_LS_BIT])
        else $error("sleep to slow took a warm-up");
    a_pll_off: assert property (@(posedge sys_clk) disable iff (!rstn)
        mode == SSW_SLEEP || mode == SSW_STOP |-> !pll_en)
        else $error("pll enabled in sleep or stop");
    a_bad_standby: assert property (@(posedge sys_clk) disable iff (!rstn)
        ce && cpu_clk_en && sleep_req && standby > `SSW_STBY_IDLE
        |=> cpu_clk_en)
        else $error("reserved standby code entered a low power mode");
    c_stop_cycle: cover property (@(posedge sys_clk) disable iff (!rstn)
        mode == SSW_STOP ##1 mode == SSW_WARMUP);
    c_sleep_slow: cover property (@(posedge sys_clk) disable iff (!rstn)
        mode == SSW_SLEEP ##1 mode == SSW_SLOW);
    c_idle_wake: cover property (@(posedge sys_clk) disable iff (!rstn)
        mode == SSW_IDLE ##1 wake_release);
    c_sleep_nmi: cover property (@(posedge sys_clk) disable iff (!rstn)
        mode == SSW_SLEEP && nmi_sync);
endmodule : ssw_ctrl
`default_nettype wire

// ### ssw_far_model.sv
/* far side: oscillator ticks and one level interrupt source.
   assumes rstn synchronous active low and ticks read on sys_clk. */
`timescale 1ns/100ps
`default_nettype none
module ssw_far_model (
    input wire logic sys_clk,   // system clock
    input wire logic rstn,      // sync reset, active low
    input wire logic hs_en,     // fast osc enable
    input wire logic ls_en,     // slow osc enable
    input wire logic raise,     // start a level request
    input wire logic released,  // device left its mode
    output logic hs_tick,       // fast tick
    output logic ls_tick,       // slow tick
    output logic irq_level      // held level request
);
    logic ph;
    // a stopped oscillator gives no ticks at all
    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            {ph, hs_tick, ls_tick, irq_level} <= 4'h0;
        end else begin
            ph <= !ph;
            hs_tick <= hs_en;
            ls_tick <= ls_en && ph;
            if (raise) begin
                irq_level <= 1'b1;
            end else if (released) begin
                irq_level <= 1'b0;
            end
        end
    end
endmodule : ssw_far_model
`default_nettype wire

// ### tb_ssw_ctrl.sv
/* bench for ssw_ctrl: registers over the bus, idle/sleep/stop wake.
   assumes the far model supplies ticks and the timer level. */
`timescale 1ns/100ps
`default_nettype none
module tb_ssw_ctrl;
    import ssw_pkg::*;
    logic sys_clk = 0, rstn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [7:0] haddr = 0, ext = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 0;
    logic [31:0] hwdata = 0, hrdata, q;
    logic sreq = 0, cie = 1, nmi = 0, wdt = 0, raise = 0, hs, ls, tirq;
    logic rel, hs_en, ls_en, by_nmi, cclk, sclk, pll, ce = 1;
    logic [2:0] sbi = 0;
    ssw_mode_type mode;
    int errors = 0, checks_done = 0;
    ssw_ctrl dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .sleep_req(sreq),
        .cpu_irq_enabled(cie), .external_pin_interrupts(ext),
        .nmi_pin(nmi), .watchdog_nmi_request(wdt), .rtc_interrupt(1'b0),
        .timer_interrupt({9'h0, tirq}), .capture_interrupt(14'h0),
        .serial_receive_interrupt(3'h0), .serial_transmit_interrupt(3'h0),
        .serial_bus_interrupt(sbi), .converter_interrupt(3'h0),
        .hs_tick(hs), .ls_tick(ls), .mode(mode), .cpu_clk_en(cclk),
        .sys_clk_en(sclk), .pll_en(pll), .hs_osc_en(hs_en),
        .ls_osc_en(ls_en),
        .wake_release(rel), .wake_by_nmi(by_nmi));
    ssw_far_model far (.sys_clk(sys_clk), .rstn(rstn), .hs_en(hs_en),
        .ls_en(ls_en), .raise(raise), .released(rel), .hs_tick(hs),
        .ls_tick(ls), .irq_level(tirq));
    initial begin
        forever #50 sys_clk = !sys_clk;
    end
    task report_and_stop;
        if (errors == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    task chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // waits for a level on one of three design outputs, bounded
    task await(input int which, input int lim);
        int i;
        i = 0;
        do begin
            @(posedge sys_clk);
            i++;
        end while (!(which == 0 ? hreadyout === 1'b1 : which == 1 ?
            rel === 1'b1 : mode === SSW_WARMUP) && i < lim);
        if (i >= lim) begin
            errors++;
            report_and_stop();
        end
    endtask : await
    task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        {hsel, htrans, haddr, hwrite, hsize} <= {1'b1, 2'h2, a, w, 3'h2};
        await(0, 20);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
        await(0, 20);
        q = hrdata;
    endtask : ahb
    task enter(input logic [2:0] code, input ssw_mode_type m);
        ahb(1, 8'h00, {29'h0, code});
        @(posedge sys_clk) sreq <= 1'b1;
        @(posedge sys_clk) sreq <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk("mode in", 32'(mode), 32'(m));
    endtask : enter
    // a source not allowed in this mode must leave it standing
    task no_wake(input ssw_mode_type m);
        repeat (30) @(posedge sys_clk);
        chk("mode held", 32'(mode), 32'(m));
        chk("no release", 32'(rel), 32'h0);
        chk("cpu gated", 32'(cclk), 32'h0);
        chk("pll off", 32'(pll), 32'h0);
        chk("fast osc", 32'(hs_en), 32'h0);
        chk("slow osc", 32'(ls_en), 32'(m == SSW_SLEEP));
    endtask : no_wake
    task back_warm;
        await(2, 40);
        chk("warming", 32'(mode), 32'(SSW_WARMUP));
        chk("sys gated", 32'(sclk), 32'h0);
        await(1, 20000);
        @(posedge sys_clk);
        chk("back", 32'(mode), 32'(SSW_NORMAL));
    endtask : back_warm
    initial begin
        repeat (20) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        chk("reset mode", 32'(mode), 32'(SSW_NORMAL));
        ahb(0, 8'h04, 0);
        chk("osc reset", q, 32'h0000_0770);
        ahb(1, 8'h04, 32'h0000_0700);
        ahb(0, 8'h04, 0);
        chk("warmup_time", q, 32'h0000_0700);
        ahb(0, 8'h10, 0);
        chk("unmapped", q, 32'h0);
        ahb(1, 8'h08, 32'h0000_0001);
        enter(3'h3, SSW_IDLE);
        @(posedge sys_clk) raise <= 1'b1;
        @(posedge sys_clk) raise <= 1'b0;
        await(1, 20);
        @(posedge sys_clk);
        chk("idle out", 32'(mode), 32'(SSW_NORMAL));
        enter(3'h2, SSW_SLEEP);
        @(posedge sys_clk) {raise, wdt} <= 2'b11;
        @(posedge sys_clk) raise <= 1'b0;
        no_wake(SSW_SLEEP);
        @(posedge sys_clk) ext <= 8'h01;
        back_warm();
        @(posedge sys_clk) ext <= 8'h00;
        enter(3'h1, SSW_STOP);
        @(posedge sys_clk) wdt <= 1'b1;
        no_wake(SSW_STOP);
        @(posedge sys_clk) {wdt, nmi} <= 2'b01;
        back_warm();
        chk("by nmi", 32'(by_nmi), 32'h1);
        nmi <= 1'b0;
        enter(3'h5, SSW_NORMAL);
        ahb(1, 8'h04, 32'h0001_1701);
        ahb(0, 8'h0C, 0);
        chk("sw warm", q, 32'h0000_0069);
        enter(3'h2, SSW_SLEEP);
        @(posedge sys_clk) ext <= 8'h01;
        await(1, 20);
        @(posedge sys_clk);
        chk("slow back", 32'(mode), 32'(SSW_SLOW));
        ext <= 8'h00;
        enter(3'h3, SSW_IDLE);
        @(posedge sys_clk) {ce, sbi} <= 4'h4;
        repeat (5) @(posedge sys_clk);
        chk("frozen", 32'(mode), 32'(SSW_IDLE));
        ce <= 1'b1;
        await(1, 20);
        sbi <= 3'h0;
        @(posedge sys_clk);
        chk("idle sbi", 32'(mode), 32'(SSW_SLOW));
        ahb(1, 8'h04, 32'h0001_0700);
        enter(3'h1, SSW_STOP);
        rstn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rstn <= 1'b1;
        @(posedge sys_clk);
        chk("reset stop", 32'(mode), 32'(SSW_NORMAL));
        ahb(0, 8'h0C, 0);
        chk("no warm", q, 32'h0000_0000);
        report_and_stop();
    end
endmodule : tb_ssw_ctrl
`default_nettype wire
